// *** rtl/pmc_pkg.sv ***
// Package of constants and carrier types for the performance event counter block.
package pmc_pkg;

   // ****************************************************************
   // Sizes.
   // ****************************************************************
   localparam int NUM_CNT = 6;
   localparam int CNT_W = 32;
   localparam int CYC_W = 64;
   localparam int EVB_W = 168;
   localparam int SEL_W = 8;
   localparam int ADDR_W = 8;

   // ****************************************************************
   // Event selection codes; every other code is reserved and counts nothing.
   // ****************************************************************
   localparam logic [SEL_W-1:0] EV_SW_BUMP = 8'h00;
   localparam logic [SEL_W-1:0] EV_IC_MISS = 8'h01;
   localparam logic [SEL_W-1:0] EV_IX_REFILL = 8'h02;
   localparam logic [SEL_W-1:0] EV_DC_MISS = 8'h03;
   localparam logic [SEL_W-1:0] EV_DC_LOOKUP = 8'h04;
   localparam logic [SEL_W-1:0] EV_DX_REFILL = 8'h05;
   localparam logic [SEL_W-1:0] EV_RETIRED = 8'h08;
   localparam logic [SEL_W-1:0] EV_EXC_ENTRY = 8'h09;
   localparam logic [SEL_W-1:0] EV_EXC_EXIT = 8'h0A;
   localparam logic [SEL_W-1:0] EV_CTX_WRITE = 8'h0B;
   localparam logic [SEL_W-1:0] EV_BR_MISP = 8'h10;
   localparam logic [SEL_W-1:0] EV_CYCLES = 8'h11;
   localparam logic [SEL_W-1:0] EV_PREDICTABLE_BRANCH_EVENT = 8'h12;
   localparam logic [SEL_W-1:0] EV_MEM_ACC = 8'h13;
   localparam logic [SEL_W-1:0] EV_IC_LOOKUP = 8'h14;
   localparam logic [SEL_W-1:0] EV_CHAIN = 8'h1E;

   // ****************************************************************
   // Bit positions on the exported event bus (low bit of a field).
   // ****************************************************************
   localparam int BP_SW = 0;
   localparam int BP_ICMISS = 1;
   localparam int BP_IXLAT = 2;
   localparam int BP_DCLK = 3;
   localparam int BP_DXLAT = 6;
   localparam int BP_RET = 8;
   localparam int BP_EXIN = 12;
   localparam int BP_EXOUT = 13;
   localparam int BP_BRMIS = 14;
   localparam int BP_CYC = 15;
   localparam int BP_BRPRED = 16;
   localparam int BP_MEM = 17;
   localparam int BP_ICLK = 20;
   localparam int BP_CTX = 156;
   localparam int BP_DCMISS = 167;

   // ****************************************************************
   // Register map (byte offsets) and fields.
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CNTEN = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_OVSTAT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CYC_LO = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CYC_HI = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_EVCNT = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_EVSEL = 8'h40;
   localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam int CTRL_CYCCLR_BIT = 2;
   localparam int CYC_BIT = 31;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CNTEN_RST = 32'h0000_0000;
   localparam logic [SEL_W-1:0] EVSEL_RST = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // ****************************************************************
   // Carrier types.
   // ****************************************************************
   typedef struct packed {
      logic sw_bump;
      logic icache_miss;
      logic ixlat_refill;
      logic dcache_miss;
      logic [2:0] dcache_lookup;
      logic [1:0] dxlat_refill;
      logic [3:0] retired;
      logic exc_entry;
      logic exc_exit;
      logic ctx_write;
      logic br_mispredict;
      logic predictable_branch_event;
      logic [2:0] mem_access;
      logic icache_lookup;
   } pmc_events_t;

   typedef struct packed {
      logic powered;
      logic os_lock;
      logic os_dlock;
      logic ext_disable;
      logic auth_ok;
   } pmc_perm_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } pmc_sreq_t;

endpackage

// *** rtl/pmc_event_counter.sv ***
// Performance monitor: event bus, six event counters, cycle counter, AHB and system ports.
`timescale 1ns/10ps
module pmc_event_counter
   import pmc_pkg::*;
#(
   parameter int NCNT = NUM_CNT
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hreadyin,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // External access permission state.
   input wire pmc_perm_t perm,
   // Internal system register port.
   input wire pmc_sreq_t sreq,
   output logic sr_ack,
   output logic [31:0] sr_rdata,
   // Event pulses from the core units and the exported event bus.
   input wire pmc_events_t events,
   output logic [EVB_W-1:0] event_bus
);

   // ****************************************************************
   // State.
   // ****************************************************************
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [31:0] cnten_ff, nxt_cnten;
   logic [31:0] ovstat_ff, nxt_ovstat;
   logic [CYC_W-1:0] cyc_ff, nxt_cyc;
   logic [CNT_W-1:0] cnt_ff [NCNT];
   logic [CNT_W-1:0] nxt_cnt [NCNT];
   logic [SEL_W-1:0] sel_ff [NCNT];
   logic [SEL_W-1:0] nxt_sel [NCNT];
   logic [EVB_W-1:0] evb_ff, nxt_evb;
   logic dph_wr_ff, nxt_dph_wr;
   logic [ADDR_W-1:0] dph_addr_ff, nxt_dph_addr;
   logic [31:0] hrdata_ff, nxt_hrdata;
   logic hready_ff;
   logic sr_ack_ff, nxt_sr_ack;
   logic [31:0] sr_rdata_ff, nxt_sr_rdata;

   // Shared write port and helpers.
   logic ext_ok;
   logic addr_ok;
   logic ahb_req;
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic sr_take;
   logic [NCNT-1:0] wrap;
   logic [NCNT-1:0] cnt_wr;
   logic cyc_wr;

   // ****************************************************************
   // Functions.
   // ****************************************************************
   // Amount that a selection code adds in one cycle; reserved codes add nothing.
   function automatic logic [3:0] evt_amount(input logic [SEL_W-1:0] sel,
                                             input logic [EVB_W-1:0] evb);
      logic [3:0] amt;
      amt = 4'h0;
      unique case (sel)
         EV_SW_BUMP: amt = {3'h0, evb[BP_SW]};
         EV_IC_MISS: amt = {3'h0, evb[BP_ICMISS]};
         EV_IX_REFILL: amt = {3'h0, evb[BP_IXLAT]};
         EV_DC_MISS: amt = {3'h0, evb[BP_DCMISS]};
         EV_DC_LOOKUP: amt = {1'h0, evb[BP_DCLK +: 3]};
         EV_DX_REFILL: amt = {2'h0, evb[BP_DXLAT +: 2]};
         EV_RETIRED: amt = evb[BP_RET +: 4];
         EV_EXC_ENTRY: amt = {3'h0, evb[BP_EXIN]};
         EV_EXC_EXIT: amt = {3'h0, evb[BP_EXOUT]};
         EV_CTX_WRITE: amt = {3'h0, evb[BP_CTX]};
         EV_BR_MISP: amt = {3'h0, evb[BP_BRMIS]};
         EV_CYCLES: amt = {3'h0, evb[BP_CYC]};
         EV_PREDICTABLE_BRANCH_EVENT: amt = {3'h0, evb[BP_BRPRED]};
         EV_MEM_ACC: amt = {1'h0, evb[BP_MEM +: 3]};
         EV_IC_LOOKUP: amt = {3'h0, evb[BP_ICLK]};
         default: amt = 4'h0;
      endcase
      return amt;
   endfunction

   // Read view of the register map, shared by both access ports.
   function automatic logic [31:0] rd_reg(input logic [ADDR_W-1:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a == OFS_CTRL) begin
         d = ctrl_ff;
      end
      if (a == OFS_CNTEN) begin
         d = cnten_ff;
      end
      if (a == OFS_OVSTAT) begin
         d = ovstat_ff;
      end
      if (a == OFS_CYC_LO) begin
         d = cyc_ff[31:0];
      end
      if (a == OFS_CYC_HI) begin
         d = cyc_ff[63:32];
      end
      for (int k = 0; k < NCNT; k++) begin
         if (a == OFS_EVCNT + ADDR_W'(k) * REG_STRIDE) begin
            d = cnt_ff[k];
         end
         if (a == OFS_EVSEL + ADDR_W'(k) * REG_STRIDE) begin
            d = {24'h0, sel_ff[k]};
         end
      end
      return d;
   endfunction

   // ****************************************************************
   // Access arbitration.
   // ****************************************************************
   // An external access is allowed only when every gate opens; a denied read
   // returns zero and a denied write is dropped, with an OKAY response.
   assign ext_ok = perm.powered & ~perm.os_dlock & ~perm.os_lock & ~perm.ext_disable
                   & perm.auth_ok;
   assign addr_ok = (haddr[31:ADDR_W] == 24'h0) && (haddr[1:0] == 2'h0);
   assign ahb_req = hsel & hreadyin & (htrans == HTRANS_NONSEQ);
   // The bus data phase owns the write port; the system port waits a cycle.
   assign sr_take = sreq.valid & ~sr_ack_ff & ~dph_wr_ff;
   assign wr_en = dph_wr_ff | (sr_take & sreq.write);
   assign wr_addr = dph_wr_ff ? dph_addr_ff : sreq.addr;
   assign wr_data = dph_wr_ff ? hwdata : sreq.wdata;

   // Bus and system port next values.
   always_comb begin
      nxt_dph_wr = ahb_req & hwrite & ext_ok & addr_ok;
      nxt_dph_addr = haddr[ADDR_W-1:0];
      nxt_hrdata = hrdata_ff;
      if (ahb_req && !hwrite) begin
         nxt_hrdata = (ext_ok && addr_ok) ? rd_reg(haddr[ADDR_W-1:0]) : 32'h0000_0000;
      end
      nxt_sr_ack = sr_take;
      nxt_sr_rdata = sr_take ? rd_reg(sreq.addr) : sr_rdata_ff;
   end

   // Bus and system port registers; the slave never waits or errors.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_ff <= 1'b0;
         dph_addr_ff <= 8'h00;
         hrdata_ff <= 32'h0000_0000;
         hready_ff <= 1'b1;
         sr_ack_ff <= 1'b0;
         sr_rdata_ff <= 32'h0000_0000;
      end else begin
         dph_wr_ff <= nxt_dph_wr;
         dph_addr_ff <= nxt_dph_addr;
         hrdata_ff <= nxt_hrdata;
         hready_ff <= 1'b1;
         sr_ack_ff <= nxt_sr_ack;
         sr_rdata_ff <= nxt_sr_rdata;
      end
   end

   // ****************************************************************
   // Event bus.
   // ****************************************************************
   // The core units qualify each pulse themselves (condition pass, cacheable,
   // no maintenance); this block only places them and counts them.
   always_comb begin
      nxt_evb = '0;
      nxt_evb[BP_SW] = events.sw_bump;
      nxt_evb[BP_ICMISS] = events.icache_miss;
      nxt_evb[BP_IXLAT] = events.ixlat_refill;
      nxt_evb[BP_DCMISS] = events.dcache_miss;
      nxt_evb[BP_DCLK +: 3] = events.dcache_lookup;
      nxt_evb[BP_DXLAT +: 2] = events.dxlat_refill;
      nxt_evb[BP_RET +: 4] = events.retired;
      nxt_evb[BP_EXIN] = events.exc_entry;
      nxt_evb[BP_EXOUT] = events.exc_exit;
      nxt_evb[BP_CTX] = events.ctx_write;
      nxt_evb[BP_BRMIS] = events.br_mispredict;
      nxt_evb[BP_CYC] = 1'b1;
      nxt_evb[BP_BRPRED] = events.predictable_branch_event;
      nxt_evb[BP_MEM +: 3] = events.mem_access;
      nxt_evb[BP_ICLK] = events.icache_lookup;
   end

   // ****************************************************************
   // Control registers.
   // ****************************************************************
   assign cyc_wr = wr_en && ((wr_addr == OFS_CYC_LO) || (wr_addr == OFS_CYC_HI));

   // Clear bits in the control word are strobes, so they never stay set.
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_ctrl[CTRL_CLR_BIT] = 1'b0;
      nxt_ctrl[CTRL_CYCCLR_BIT] = 1'b0;
      nxt_cnten = cnten_ff;
      nxt_ovstat = ovstat_ff;
      if (wr_en && wr_addr == OFS_CTRL) begin
         nxt_ctrl = wr_data & 32'h0000_0007;
      end
      if (wr_en && wr_addr == OFS_CNTEN) begin
         nxt_cnten = wr_data & {1'b1, 25'h0, 6'h3F};
      end
      // Write one to clear; a wrap in the same cycle still sets its bit.
      if (wr_en && wr_addr == OFS_OVSTAT) begin
         nxt_ovstat = ovstat_ff & ~wr_data;
      end
      nxt_ovstat[NCNT-1:0] = nxt_ovstat[NCNT-1:0] | wrap;
      if (ctrl_ff[CTRL_EN_BIT] && cnten_ff[CYC_BIT] && !cyc_wr && !ctrl_ff[CTRL_CYCCLR_BIT]
          && (&cyc_ff)) begin
         nxt_ovstat[CYC_BIT] = 1'b1;
      end
      // Cycle counter: 64 bits wide, written a half at a time.
      nxt_cyc = cyc_ff;
      if (ctrl_ff[CTRL_CYCCLR_BIT]) begin
         nxt_cyc = '0;
      end else if (cyc_wr && wr_addr == OFS_CYC_LO) begin
         nxt_cyc[31:0] = wr_data;
      end else if (cyc_wr) begin
         nxt_cyc[63:32] = wr_data;
      end else if (ctrl_ff[CTRL_EN_BIT] && cnten_ff[CYC_BIT]) begin
         nxt_cyc = cyc_ff + 64'h1;
      end
   end

   // Control and cycle counter registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= CTRL_RST;
         cnten_ff <= CNTEN_RST;
         ovstat_ff <= 32'h0000_0000;
         cyc_ff <= '0;
         evb_ff <= '0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         cnten_ff <= nxt_cnten;
         ovstat_ff <= nxt_ovstat;
         cyc_ff <= nxt_cyc;
         evb_ff <= nxt_evb;
      end
   end

   // ****************************************************************
   // Event counters.
   // ****************************************************************
   // Each counter decodes its own selection, so any event fits any counter, except chain, which only an odd counter counts.
   for (genvar i = 0; i < NCNT; i++) begin : g_cnt
      logic [3:0] amt;
      logic [CNT_W:0] sum;
      logic sel_wr;
      assign cnt_wr[i] = wr_en && (wr_addr == OFS_EVCNT + ADDR_W'(i) * REG_STRIDE);
      assign sel_wr = wr_en && (wr_addr == OFS_EVSEL + ADDR_W'(i) * REG_STRIDE);

      // Chain only links an odd counter to its even neighbour; an even counter
      // set to chain sees no amount at all.
      always_comb begin
         amt = 4'h0;
         if (ctrl_ff[CTRL_EN_BIT] && cnten_ff[i]) begin
            if (sel_ff[i] == EV_CHAIN) begin
               amt = ((i % 2) == 1) ? {3'h0, wrap[(i / 2) * 2]} : 4'h0;
            end else begin
               amt = evt_amount(sel_ff[i], nxt_evb);
            end
         end
         sum = {1'b0, cnt_ff[i]} + {29'h0, amt};
         nxt_cnt[i] = sum[CNT_W-1:0];
         nxt_sel[i] = sel_wr ? wr_data[SEL_W-1:0] : sel_ff[i];
         if (ctrl_ff[CTRL_CLR_BIT]) begin
            nxt_cnt[i] = '0;
         end else if (cnt_wr[i]) begin
            nxt_cnt[i] = wr_data;
         end
      end
      // A written or cleared counter does not report a wrap that cycle.
      assign wrap[i] = sum[CNT_W] & ~cnt_wr[i] & ~ctrl_ff[CTRL_CLR_BIT];

      // Counter and selection registers.
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cnt_ff[i] <= '0;
            sel_ff[i] <= EVSEL_RST;
         end else begin
            cnt_ff[i] <= nxt_cnt[i];
            sel_ff[i] <= nxt_sel[i];
         end
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign hreadyout = hready_ff;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;
   assign sr_ack = sr_ack_ff;
   assign sr_rdata = sr_rdata_ff;
   assign event_bus = evb_ff;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Helper: counter 0 and 1 are left alone by software and the clear strobe.
   logic quiet01;
   assign quiet01 = !cnt_wr[0] && !cnt_wr[1] && !ctrl_ff[CTRL_CLR_BIT];
   // Counter 2 is the even counter that the chain and reserved checks watch.
   logic quiet2;
   assign quiet2 = !cnt_wr[2] && !ctrl_ff[CTRL_CLR_BIT];

   sequence even_wraps;
      sel_ff[1] == EV_CHAIN && ctrl_ff[CTRL_EN_BIT] && cnten_ff[1] && wrap[0] && quiet01;
   endsequence

   cyc_count_a: assert property (
      ctrl_ff[CTRL_EN_BIT] && cnten_ff[CYC_BIT] && !cyc_wr && !ctrl_ff[CTRL_CYCCLR_BIT]
      |=> cyc_ff == $past(cyc_ff) + 64'h1)
      else $error("cycle counter did not advance by one");

   cycle_event_a: assert property (
      ctrl_ff[CTRL_EN_BIT] && cnten_ff[0] && sel_ff[0] == EV_CYCLES && quiet01
      |=> cnt_ff[0] == $past(cnt_ff[0]) + 32'h1)
      else $error("cycle event did not add one");

   reserved_code_a: assert property (
      sel_ff[2] == 8'h06 && quiet2 |=> $stable(cnt_ff[2]))
      else $error("reserved code changed a counter");

   chain_even_a: assert property (
      sel_ff[2] == EV_CHAIN && quiet2 |=> $stable(cnt_ff[2]))
      else $error("even counter counted the chain event");

   chain_odd_a: assert property (
      even_wraps |=> cnt_ff[1] == $past(cnt_ff[1]) + 32'h1 && ovstat_ff[0])
      else $error("odd counter missed an even wrap");

   retired_add_a: assert property (
      ctrl_ff[CTRL_EN_BIT] && cnten_ff[0] && sel_ff[0] == EV_RETIRED && quiet01
      |=> cnt_ff[0] == $past(cnt_ff[0]) + {28'h0, $past(events.retired)})
      else $error("retired count not added whole");

   denied_read_a: assert property (
      ahb_req && !hwrite && !ext_ok |=> hrdata_ff == 32'h0000_0000 && hreadyout)
      else $error("denied read returned data");

   sys_port_a: assert property (
      sreq.valid && !sr_ack_ff && !dph_wr_ff |=> sr_ack_ff ##1 !sr_ack_ff)
      else $error("system port did not answer in one cycle");

   bus_cycle_a: assert property (
      hresetn |=> event_bus[BP_CYC] && event_bus[BP_RET +: 4] == $past(events.retired))
      else $error("event bus cycle bit or retired field wrong");

endmodule

// *** sim/pmc_core_model.sv ***
// Behavioural model of the core units that drive event pulses into the counter block.
`timescale 1ns/10ps
module pmc_core_model
   import pmc_pkg::*;
(
   // Clock and reset.
   hclk,
   hresetn,
   // Burst request from the bench.
   go,
   len,
   pat,
   // Event pulses towards the block.
   events
);
   input wire logic hclk;
   input wire logic hresetn;
   input wire logic go;
   input wire logic [7:0] len;
   input wire pmc_events_t pat;
   output pmc_events_t events;
   logic [7:0] left_ff;
   logic [7:0] nxt_left;
   // Count down the cycles of the burst that are still to be sent.
   always_comb begin
      nxt_left = left_ff;
      if (go) begin
         nxt_left = len;
      end else if (left_ff != 8'h00) begin
         nxt_left = left_ff - 8'h01;
      end
   end
   // Register the count.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         left_ff <= 8'h00;
      end else begin
         left_ff <= nxt_left;
      end
   end
   // Pulses drop to zero outside a burst, so a stale pattern is never counted twice.
   assign events = (left_ff != 8'h00) ? pat : '0;
endmodule

// *** sim/tb.sv ***
// Self-checking testbench for the performance event counter block.
`timescale 1ns/10ps
module tb;
   import pmc_pkg::*;
   // ****************************************************************
   // Signals and tables.
   // ****************************************************************
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, sr_rdata, rd, a;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] len = 8'h00;
   logic hreadyout, hresp, sr_ack;
   logic [EVB_W-1:0] event_bus, eb;
   pmc_perm_t perm = 5'h11;
   pmc_sreq_t sreq = '0;
   pmc_events_t events, pat;
   int num_errors = 0, n_compared = 0, cycles = 0;
   logic [7:0] cds [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09,
      8'h0A, 8'h0B, 8'h10, 8'h12, 8'h13, 8'h14, 8'h06};
   int mul [15] = '{1, 1, 1, 1, 5, 2, 9, 1, 1, 1, 1, 1, 6, 1, 0};
   int one_bits [11] = '{BP_SW, BP_ICMISS, BP_IXLAT, BP_EXIN, BP_EXOUT, BP_BRMIS, BP_CYC,
      BP_BRPRED, BP_ICLK, BP_CTX, BP_DCMISS};
   // Free-running bus clock.
   always #12.5 hclk = ~hclk;
   pmc_event_counter pmc_event_counter_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hreadyin(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .perm(perm), .sreq(sreq), .sr_ack(sr_ack), .sr_rdata(sr_rdata), .events(events),
      .event_bus(event_bus));
   pmc_core_model pmc_core_model_inst (.hclk(hclk), .hresetn(hresetn), .go(go), .len(len),
      .pat(pat), .events(events));
   // ****************************************************************
   // Tasks.
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bus(input logic [EVB_W-1:0] got, input logic [EVB_W-1:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: event bus %h, expected %h", $time, got, exp);
      end
   endtask
   // One AHB single transfer; the slave may stretch either phase with hready.
   task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= ad;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // One system port request, held until the acknowledge is seen.
   task automatic sys(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      sreq <= '{1'b1, wr, ad, wd};
      do @(posedge hclk); while (sr_ack !== 1'b1);
      rd = sr_rdata;
      sreq <= '0;
      @(posedge hclk);
   endtask
   // Event burst of n cycles; the exported bus is looked at while the burst runs.
   task automatic burst(input logic [7:0] n);
      go <= 1'b1;
      len <= n;
      @(posedge hclk);
      go <= 1'b0;
      repeat (2) @(posedge hclk);
      chk_bus(event_bus, eb);
      repeat (n + 2) @(posedge hclk);
   endtask
   function automatic logic [31:0] ra(input logic [7:0] base, input int k);
      return {24'h0, base} + 32'(4 * k);
   endfunction
   task automatic wrap_up;
      $display("Errors: %0d, comparisons: %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Cut a hang short; the whole run needs well under a thousand cycles.
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         $display("Error at %0t: timeout", $time);
         wrap_up();
      end
   end
   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      pat = '1;
      pat.dcache_lookup = 3'h5;
      pat.dxlat_refill = 2'h2;
      pat.retired = 4'h9;
      pat.mem_access = 3'h6;
      eb = '0;
      foreach (one_bits[j]) eb[one_bits[j]] = 1'b1;
      eb[BP_DCLK +: 3] = 3'h5;
      eb[BP_DXLAT +: 2] = 2'h2;
      eb[BP_RET +: 4] = 4'h9;
      eb[BP_MEM +: 3] = 3'h6;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      chk_bus(event_bus, EVB_W'(1) << BP_CYC);
      ahb(1'b0, ra(OFS_CTRL, 0), 32'h0);
      chk(rd, CTRL_RST);
      ahb(1'b0, ra(OFS_CNTEN, 0), 32'h0);
      chk(rd, CNTEN_RST);
      ahb(1'b0, ra(OFS_EVSEL, 0), 32'h0);
      chk(rd, 32'(EVSEL_RST));
      ahb(1'b0, 32'h0000_0060, 32'h0);
      chk(rd, 32'h0);
      // Every code except cycles and chain on a rotating counter, with a distinct count on each wide field.
      ahb(1'b1, ra(OFS_CNTEN, 0), 32'h8000_003F);
      for (int i = 0; i < 15; i++) begin
         ahb(1'b1, ra(OFS_EVSEL, i % 6), 32'(cds[i]));
         ahb(1'b1, ra(OFS_CTRL, 0), 32'h3);
         burst(8'h04);
         ahb(1'b0, ra(OFS_EVCNT, i % 6), 32'h0);
         chk(rd, 32'(4 * mul[i]));
      end
      // Reads two cycles apart on the cycle event and on the cycle counter.
      ahb(1'b1, ra(OFS_EVSEL, 0), 32'(EV_CYCLES));
      ahb(1'b0, ra(OFS_EVCNT, 0), 32'h0);
      a = rd;
      ahb(1'b0, ra(OFS_EVCNT, 0), 32'h0);
      chk(rd - a, 32'h2);
      ahb(1'b0, ra(OFS_CYC_LO, 0), 32'h0);
      a = rd;
      ahb(1'b0, ra(OFS_CYC_LO, 0), 32'h0);
      chk(rd - a, 32'h2);
      // A counter whose enable bit is off must stand still.
      ahb(1'b1, ra(OFS_EVSEL, 0), 32'(EV_SW_BUMP));
      ahb(1'b1, ra(OFS_CNTEN, 0), 32'h8000_003E);
      ahb(1'b1, ra(OFS_CTRL, 0), 32'h3);
      burst(8'h03);
      ahb(1'b0, ra(OFS_EVCNT, 0), 32'h0);
      chk(rd, 32'h0);
      // Counter 0 wraps once; odd neighbour chains, even one never moves.
      ahb(1'b1, ra(OFS_CNTEN, 0), 32'h8000_003F);
      ahb(1'b1, ra(OFS_EVSEL, 1), 32'(EV_CHAIN));
      ahb(1'b1, ra(OFS_EVSEL, 2), 32'(EV_CHAIN));
      ahb(1'b1, ra(OFS_CTRL, 0), 32'h3);
      ahb(1'b1, ra(OFS_EVCNT, 0), 32'hFFFF_FFFE);
      burst(8'h03);
      for (int k = 0; k < 3; k++) begin
         ahb(1'b0, ra(OFS_EVCNT, k), 32'h0);
         chk(rd, (k == 2) ? 32'h0 : 32'h1);
      end
      ahb(1'b0, ra(OFS_OVSTAT, 0), 32'h0);
      chk(rd, 32'h1);
      // Each denial condition alone blocks bus access; the system port is never denied.
      for (int j = 0; j < 5; j++) begin
         perm <= pmc_perm_t'(5'h11 ^ (5'h10 >> j));
         ahb(1'b1, ra(OFS_EVCNT, 0), 32'h0000_0055);
         ahb(1'b0, ra(OFS_EVCNT, 0), 32'h0);
         chk(rd, 32'h0);
         chk({31'h0, hresp}, 32'h0);
      end
      sys(1'b1, OFS_EVCNT + 8'h0C, 32'h0000_1234);
      sys(1'b0, OFS_EVCNT + 8'h0C, 32'h0);
      chk(rd, 32'h0000_1234);
      perm <= 5'h11;
      ahb(1'b0, ra(OFS_EVCNT, 0), 32'h0);
      chk(rd, 32'h1);
      ahb(1'b0, ra(OFS_EVCNT, 3), 32'h0);
      chk(rd, 32'h0000_1234);
      wrap_up();
   end
endmodule
